// ### rtl/crs_consts.svh
// crs_consts.svh: numeric constants for the core register set
// assumes inclusion by crs_pkg and by the design modules
`ifndef CRS_CONSTS_SVH
`define CRS_CONSTS_SVH
`define CRS_DW 8
`define CRS_AW 16
`define CRS_ZERO_BYTE 8'h00
`define CRS_PAGE0_HI 8'h00
`define CRS_PAGE1_HI 8'h01
`define CRS_SP_RESET 8'hFF
`define CRS_PC_RESET 16'h0000
`define CRS_PS_RESET 8'h04
`define CRS_MODE_ADDR 16'h003B
`define CRS_MODE_RESET 8'h00
`define CRS_SPS_BIT 2
`define CRS_ONE_BYTE 8'h01
`endif

// ### rtl/crs_pkg.sv
// crs_pkg: types shared by the core register set
// assumes crs_consts.svh is on the include path
`include "crs_consts.svh"
package crs_pkg;
  // register selector for write and read ports
  typedef enum logic [2:0] {
    CRS_SEL_ACC,
    CRS_SEL_IDX1,
    CRS_SEL_IDX2,
    CRS_SEL_SP,
    CRS_SEL_PS,
    CRS_SEL_PCL,
    CRS_SEL_PCU,
    CRS_SEL_MODE
  } crs_sel_t;
  // index source for effective address
  typedef enum logic [1:0] {
    CRS_IDX_NONE,
    CRS_IDX_FIRST,
    CRS_IDX_SECOND
  } crs_idx_t;
  // stack operation request
  typedef enum logic [1:0] {
    CRS_STK_IDLE,
    CRS_STK_PUSH,
    CRS_STK_POP
  } crs_stk_t;
  // register write request
  typedef struct packed {
    logic we;
    crs_sel_t sel;
    logic [7:0] data;
  } crs_wr_t;
  // effective address request
  typedef struct packed {
    crs_idx_t idx;
    logic [15:0] operand;
  } crs_ea_req_t;
  // decoded instruction class
  typedef enum logic [2:0] {
    CRS_INS_OTHER,
    CRS_INS_HIGH_SPEED,
    CRS_INS_LOW_SPEED,
    CRS_INS_HALT_OSC,
    CRS_INS_WAIT,
    CRS_INS_PRODUCT,
    CRS_INS_QUOTIENT
  } crs_ins_t;
endpackage

// ### rtl/crs_stack_addr.sv
// crs_stack_addr: stack pointer update and stack address forming
// assumes push and pop requests come from the core sequencer on clk_i
`timescale 1ns/100ps
`include "crs_consts.svh"
module crs_stack_addr
  import crs_pkg::*;
(
  input wire logic [7:0] sp_i,
  input wire logic page_sel_i,
  input wire crs_stk_t op_i,
  output logic [7:0] nxt_sp_o,
  output logic [15:0] stack_addr_o
);
  // wrap stays inside the page since only the low byte moves
  wire logic [7:0] sp_dec = sp_i - `CRS_ONE_BYTE;
  wire logic [7:0] sp_inc = sp_i + `CRS_ONE_BYTE;
  wire logic [7:0] page_hi = page_sel_i ? `CRS_PAGE1_HI : `CRS_PAGE0_HI;
  // push writes at sp then decrements, pop increments then reads
  assign nxt_sp_o = (op_i == CRS_STK_PUSH) ? sp_dec : (op_i == CRS_STK_POP) ? sp_inc : sp_i;
  assign stack_addr_o = {page_hi, (op_i == CRS_STK_POP) ? sp_inc : sp_i};
endmodule

// ### rtl/crs_core_regs.sv
// crs_core_regs: programmer-visible register set of the 8-bit core
// assumes a sequencer on clk_i drives writes, stack ops and opcode classes
`timescale 1ns/100ps
`include "crs_consts.svh"
module crs_core_regs
  import crs_pkg::*;
#(
  parameter int DW = `CRS_DW
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire crs_wr_t wr_i,
  input wire logic [15:0] data_addr_i,
  input wire logic data_we_i,
  input wire logic [7:0] data_wdata_i,
  input wire crs_stk_t stk_op_i,
  input wire logic pc_inc_i,
  input wire logic pc_load_i,
  input wire logic [15:0] pc_load_val_i,
  input wire crs_ea_req_t ea_req_i,
  input wire crs_ins_t ins_class_i,
  input wire crs_sel_t rd_sel_i,
  output logic [7:0] rd_data_o,
  output logic [7:0] acc_o,
  output logic [7:0] idx1_o,
  output logic [7:0] idx2_o,
  output logic [7:0] sp_o,
  output logic [7:0] ps_o,
  output logic [15:0] pc_o,
  output logic [7:0] mode_o,
  output logic [15:0] stack_addr_o,
  output logic [15:0] eff_addr_o,
  output logic ins_legal_o
);
  // the six visible registers plus the mode register
  logic [DW-1:0] acc_ff;
  logic [DW-1:0] idx1_ff;
  logic [DW-1:0] idx2_ff;
  logic [7:0] sp_ff;
  logic [7:0] ps_ff;
  logic [7:0] pc_upper_ff;
  logic [7:0] pc_lower_ff;
  logic [7:0] mode_ff;
  logic [15:0] eff_addr_ff;
  logic [7:0] rd_data_ff;
  logic ins_legal_ff;

  // zero-extend an 8-bit index and add it to the operand
  function automatic logic [15:0] add_index(input logic [15:0] opnd, input logic [7:0] idx);
    add_index = opnd + {`CRS_ZERO_BYTE, idx};
  endfunction

  // true when the write request targets the given register
  function automatic logic sel_hit(input crs_wr_t req, input crs_sel_t sel);
    sel_hit = req.we && (req.sel == sel);
  endfunction

  // write-enable decode per register
  wire logic wr_acc = sel_hit(wr_i, CRS_SEL_ACC);
  wire logic wr_idx1 = sel_hit(wr_i, CRS_SEL_IDX1);
  wire logic wr_idx2 = sel_hit(wr_i, CRS_SEL_IDX2);
  wire logic wr_sp = sel_hit(wr_i, CRS_SEL_SP);
  wire logic wr_ps = sel_hit(wr_i, CRS_SEL_PS);
  wire logic wr_pcl = sel_hit(wr_i, CRS_SEL_PCL);
  wire logic wr_pcu = sel_hit(wr_i, CRS_SEL_PCU);
  // a data-bus store to the mode address wins over a selector write
  wire logic mode_hit = data_we_i && (data_addr_i == `CRS_MODE_ADDR);
  wire logic wr_mode = mode_hit || sel_hit(wr_i, CRS_SEL_MODE);
  wire logic [7:0] mode_wdata = mode_hit ? data_wdata_i : wr_i.data;
  wire logic page_sel = mode_ff[`CRS_SPS_BIT];

  // stack pointer arithmetic and stack address
  logic [7:0] nxt_sp_stk;
  crs_stack_addr u_stack (
    .sp_i(sp_ff),
    .page_sel_i(page_sel),
    .op_i(stk_op_i),
    .nxt_sp_o(nxt_sp_stk),
    .stack_addr_o(stack_addr_o)
  );
  // explicit write beats a stack step in the same cycle
  wire logic [7:0] nxt_sp = wr_sp ? wr_i.data : nxt_sp_stk;

  // program counter: byte writes, then load, then increment
  wire logic [15:0] pc_cur = {pc_upper_ff, pc_lower_ff};
  // byte writes let one half be patched while the other half still steps
  wire logic [15:0] pc_plus = pc_cur + {`CRS_ZERO_BYTE, `CRS_ONE_BYTE};
  wire logic [15:0] nxt_pc_base = pc_load_i ? pc_load_val_i : (pc_inc_i ? pc_plus : pc_cur);
  wire logic [7:0] nxt_pc_upper = wr_pcu ? wr_i.data : nxt_pc_base[15:8];
  wire logic [7:0] nxt_pc_lower = wr_pcl ? wr_i.data : nxt_pc_base[7:0];

  // effective address by index source
  wire logic [15:0] nxt_eff_addr =
    (ea_req_i.idx == CRS_IDX_FIRST) ? add_index(ea_req_i.operand, idx1_ff) :
    (ea_req_i.idx == CRS_IDX_SECOND) ? add_index(ea_req_i.operand, idx2_ff) :
    ea_req_i.operand;

  // instruction support check for this variant
  // speed-select classes are flagged so the sequencer can trap them
  wire logic is_high_speed = (ins_class_i == CRS_INS_HIGH_SPEED);
  wire logic is_low_speed = (ins_class_i == CRS_INS_LOW_SPEED);
  // halt, wait, product and quotient classes fall through as legal
  wire logic nxt_ins_legal = !(is_high_speed || is_low_speed);

  // read-port selection
  logic [7:0] nxt_rd_data;
  always_comb begin
    unique case (rd_sel_i)
      CRS_SEL_ACC: nxt_rd_data = acc_ff;
      CRS_SEL_IDX1: nxt_rd_data = idx1_ff;
      CRS_SEL_IDX2: nxt_rd_data = idx2_ff;
      CRS_SEL_SP: nxt_rd_data = sp_ff;
      CRS_SEL_PS: nxt_rd_data = ps_ff;
      CRS_SEL_PCL: nxt_rd_data = pc_lower_ff;
      CRS_SEL_PCU: nxt_rd_data = pc_upper_ff;
      CRS_SEL_MODE: nxt_rd_data = mode_ff;
    endcase
  end

  // accumulator: main operand and result register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc_ff <= `CRS_ZERO_BYTE;
    end else if (wr_acc) begin
      acc_ff <= wr_i.data;
    end
  end

  // first index register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      idx1_ff <= `CRS_ZERO_BYTE;
    end else if (wr_idx1) begin
      idx1_ff <= wr_i.data;
    end
  end

  // second index register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      idx2_ff <= `CRS_ZERO_BYTE;
    end else if (wr_idx2) begin
      idx2_ff <= wr_i.data;
    end
  end

  // processor status, loaded only by explicit writes here
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ps_ff <= `CRS_PS_RESET;
    end else if (wr_ps) begin
      ps_ff <= wr_i.data;
    end
  end

  // stack pointer moves on every push or pop request unless an explicit write to sp lands in the same cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sp_ff <= `CRS_SP_RESET;
    end else begin
      sp_ff <= nxt_sp;
    end
  end

  // upper program counter byte
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pc_upper_ff <= 8'(`CRS_PC_RESET >> `CRS_DW);
    end else begin
      pc_upper_ff <= nxt_pc_upper;
    end
  end

  // lower program counter byte
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pc_lower_ff <= 8'(`CRS_PC_RESET);
    end else begin
      pc_lower_ff <= nxt_pc_lower;
    end
  end

  // mode register holding the stack page bit
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_ff <= `CRS_MODE_RESET;
    end else if (wr_mode) begin
      mode_ff <= mode_wdata;
    end
  end

  // effective address, one cycle after the request
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      eff_addr_ff <= {`CRS_ZERO_BYTE, `CRS_ZERO_BYTE};
    end else begin
      eff_addr_ff <= nxt_eff_addr;
    end
  end

  // read port data, one cycle after the selector
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_ff <= `CRS_ZERO_BYTE;
    end else begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  // opcode support flag, legal out of reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ins_legal_ff <= 1'b1;
    end else begin
      ins_legal_ff <= nxt_ins_legal;
    end
  end

  assign acc_o = acc_ff;
  assign idx1_o = idx1_ff;
  assign idx2_o = idx2_ff;
  assign sp_o = sp_ff;
  assign ps_o = ps_ff;
  assign pc_o = pc_cur;
  assign mode_o = mode_ff;
  assign eff_addr_o = eff_addr_ff;
  assign rd_data_o = rd_data_ff;
  assign ins_legal_o = ins_legal_ff;
endmodule

// ### bench/crs_core_regs_props.sv
// crs_core_regs_props: port assertions for the core register set
// assumes a bind onto crs_core_regs and a single clock domain
`timescale 1ns/100ps
module crs_core_regs_props
  import crs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire crs_wr_t wr_i,
  input wire logic [15:0] data_addr_i,
  input wire logic data_we_i,
  input wire logic [7:0] data_wdata_i,
  input wire crs_stk_t stk_op_i,
  input wire crs_ea_req_t ea_req_i,
  input wire crs_ins_t ins_class_i,
  input wire logic [7:0] acc_o,
  input wire logic [7:0] idx1_o,
  input wire logic [7:0] idx2_o,
  input wire logic [7:0] sp_o,
  input wire logic [7:0] mode_o,
  input wire logic [15:0] stack_addr_o,
  input wire logic [15:0] eff_addr_o,
  input wire logic ins_legal_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // stack address, pointer motion, indexing, opcode legality, mode register and accumulator writes
  a_stack_addr_hold: assert property (stk_op_i != CRS_STK_POP |-> stack_addr_o == {7'h00, mode_o[2], sp_o})
    else $error("stack address wrong outside pop");
  a_stack_addr_pop: assert property (stk_op_i == CRS_STK_POP |-> stack_addr_o == {7'h00, mode_o[2], sp_o + 8'h01})
    else $error("stack address wrong on pop");
  a_push_sp_dec: assert property (stk_op_i == CRS_STK_PUSH && !(wr_i.we && wr_i.sel == CRS_SEL_SP) |=> sp_o == $past(sp_o) - 8'h01)
    else $error("push did not decrement");
  a_pop_sp_inc: assert property (stk_op_i == CRS_STK_POP && !(wr_i.we && wr_i.sel == CRS_SEL_SP) |=> sp_o == $past(sp_o) + 8'h01)
    else $error("pop did not increment");
  a_eff_first_idx: assert property (ea_req_i.idx == CRS_IDX_FIRST |=> eff_addr_o == $past(ea_req_i.operand) + {8'h00, $past(idx1_o)})
    else $error("first index address wrong");
  a_eff_second_idx: assert property (ea_req_i.idx == CRS_IDX_SECOND |=> eff_addr_o == $past(ea_req_i.operand) + {8'h00, $past(idx2_o)})
    else $error("second index address wrong");
  a_speed_ins_refused: assert property (ins_class_i inside {CRS_INS_HIGH_SPEED, CRS_INS_LOW_SPEED} |=> !ins_legal_o)
    else $error("speed select accepted");
  a_other_ins_legal: assert property (!(ins_class_i inside {CRS_INS_HIGH_SPEED, CRS_INS_LOW_SPEED}) |=> ins_legal_o)
    else $error("implemented opcode refused");
  a_mode_addr_hit: assert property (data_we_i && data_addr_i == 16'h003B |=> mode_o == $past(data_wdata_i))
    else $error("mode register not written");
  a_acc_write_lands: assert property (wr_i.we && wr_i.sel == CRS_SEL_ACC |=> acc_o == $past(wr_i.data))
    else $error("accumulator write lost");
  c_push_wrap: cover property (stk_op_i == CRS_STK_PUSH && sp_o == 8'h00);
  c_page_one_pop: cover property (stk_op_i == CRS_STK_POP && mode_o[2]);
  c_speed_ins: cover property (ins_class_i == CRS_INS_LOW_SPEED);
endmodule
bind crs_core_regs crs_core_regs_props u_crs_core_regs_props (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .wr_i(wr_i),
  .data_addr_i(data_addr_i),
  .data_we_i(data_we_i),
  .data_wdata_i(data_wdata_i),
  .stk_op_i(stk_op_i),
  .ea_req_i(ea_req_i),
  .ins_class_i(ins_class_i),
  .acc_o(acc_o),
  .idx1_o(idx1_o),
  .idx2_o(idx2_o),
  .sp_o(sp_o),
  .mode_o(mode_o),
  .stack_addr_o(stack_addr_o),
  .eff_addr_o(eff_addr_o),
  .ins_legal_o(ins_legal_o)
);

// ### bench/testbench.sv
// testbench: random self-checking run of the core register set
// assumes crs_pkg and crs_consts.svh are compiled ahead
`timescale 1ns/100ps
`include "crs_consts.svh"
module testbench
  import crs_pkg::*;
;
  typedef struct packed {
    logic [15:0] ea; logic lg; logic [7:0] rd; logic [7:0] sp; logic [15:0] pc;
    logic [7:0] ac; logic [7:0] x1; logic [7:0] x2; logic [7:0] ps; logic [7:0] md;
  } crs_exp_t;
  logic clk_i = 1'b0, rst_i = 1'b1, data_we_i = 1'b0, pc_inc_i = 1'b0, pc_load_i = 1'b0, ins_legal_o, inc, ld, hit;
  crs_wr_t wr_i = '0, w;
  logic [15:0] data_addr_i = 16'h0000, pc_load_val_i = 16'h0000, pc_o, stack_addr_o, eff_addr_o, da, lv, p;
  logic [7:0] data_wdata_i = 8'h00, rd_data_o, acc_o, idx1_o, idx2_o, sp_o, ps_o, mode_o, dwd;
  crs_stk_t stk_op_i = CRS_STK_IDLE, so;
  crs_ea_req_t ea_req_i = '0, ea;
  crs_ins_t ins_class_i = CRS_INS_OTHER, ic;
  crs_sel_t rd_sel_i = CRS_SEL_ACC, rs;
  logic [7:0] m [8];
  crs_exp_t q [$];
  crs_exp_t e, d;
  int mismatches = 0, num_checks = 0;
  always #4 clk_i = ~clk_i;
  crs_core_regs u_crs_core_regs (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(wr_i),
    .data_addr_i(data_addr_i),
    .data_we_i(data_we_i),
    .data_wdata_i(data_wdata_i),
    .stk_op_i(stk_op_i),
    .pc_inc_i(pc_inc_i),
    .pc_load_i(pc_load_i),
    .pc_load_val_i(pc_load_val_i),
    .ea_req_i(ea_req_i),
    .ins_class_i(ins_class_i),
    .rd_sel_i(rd_sel_i),
    .rd_data_o(rd_data_o),
    .acc_o(acc_o),
    .idx1_o(idx1_o),
    .idx2_o(idx2_o),
    .sp_o(sp_o),
    .ps_o(ps_o),
    .pc_o(pc_o),
    .mode_o(mode_o),
    .stack_addr_o(stack_addr_o),
    .eff_addr_o(eff_addr_o),
    .ins_legal_o(ins_legal_o)
  );
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // compare the oldest note with the settled registered outputs
  always @(negedge clk_i) begin
    if (q.size() > 1) begin
      e = q.pop_front();
      chk("eff_addr_o", e.ea, eff_addr_o);
      chk("ins_legal_o", {15'h0000, e.lg}, {15'h0000, ins_legal_o});
      chk("rd_data_o", {8'h00, e.rd}, {8'h00, rd_data_o});
      chk("sp_o", {8'h00, e.sp}, {8'h00, sp_o});
      chk("pc_o", e.pc, pc_o);
      chk("acc_o", {8'h00, e.ac}, {8'h00, acc_o});
      chk("idx_pair", {e.x1, e.x2}, {idx1_o, idx2_o});
      chk("ps_mode", {e.ps, e.md}, {ps_o, mode_o});
      chk("stack_addr_o", {(e.md[`CRS_SPS_BIT] ? `CRS_PAGE1_HI : `CRS_PAGE0_HI),
          (stk_op_i == CRS_STK_POP ? e.sp + `CRS_ONE_BYTE : e.sp)}, stack_addr_o);
    end
  end
  // random traffic with a reference model of every register
  initial begin
    void'($urandom(32'hCEC1));
    m = '{8'h00, 8'h00, 8'h00, `CRS_SP_RESET, `CRS_PS_RESET, 8'h00, 8'h00, `CRS_MODE_RESET};
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk("ps_sp", {`CRS_PS_RESET, `CRS_SP_RESET}, {ps_o, sp_o});
    chk("stack_addr_o", 16'h00FF, stack_addr_o);
    repeat (2000) begin
      @(posedge clk_i);
      w = '{we: 1'($urandom), sel: crs_sel_t'($urandom_range(7)), data: 8'($urandom)};
      so = crs_stk_t'($urandom_range(2));
      ea = '{idx: crs_idx_t'($urandom_range(2)), operand: 16'($urandom)};
      ic = crs_ins_t'($urandom_range(6));
      rs = crs_sel_t'($urandom_range(7));
      da = $urandom_range(1) ? 16'h003B : 16'h003A;
      hit = 1'($urandom) && da == 16'h003B;
      dwd = 8'($urandom);
      inc = 1'($urandom);
      ld = $urandom_range(7) == 0;
      lv = 16'($urandom);
      wr_i <= w;
      stk_op_i <= so;
      ea_req_i <= ea;
      ins_class_i <= ic;
      rd_sel_i <= rs;
      data_addr_i <= da;
      data_we_i <= hit | (da != 16'h003B);
      data_wdata_i <= dwd;
      pc_inc_i <= inc;
      pc_load_i <= ld;
      pc_load_val_i <= lv;
      d.ea = ea.operand + {8'h00, ea.idx == CRS_IDX_FIRST ? m[1] : ea.idx == CRS_IDX_SECOND ? m[2] : 8'h00};
      d.lg = !(ic inside {CRS_INS_HIGH_SPEED, CRS_INS_LOW_SPEED});
      d.rd = m[rs];
      p = ld ? lv : {m[6], m[5]} + {15'h0000, inc};
      if (w.we) m[w.sel] = w.data;
      if (!(w.we && w.sel == CRS_SEL_SP)) m[3] = m[3] + (so == CRS_STK_PUSH ? 8'hFF : so == CRS_STK_POP ? 8'h01 : 8'h00);
      if (hit) m[7] = dwd;
      if (!(w.we && w.sel == CRS_SEL_PCL)) m[5] = p[7:0];
      if (!(w.we && w.sel == CRS_SEL_PCU)) m[6] = p[15:8];
      d.sp = m[3];
      d.ac = m[0];
      d.x1 = m[1];
      d.x2 = m[2];
      d.ps = m[4];
      d.md = m[7];
      d.pc = {m[6], m[5]};
      q.push_back(d);
    end
    repeat (2) @(posedge clk_i);
    wrap_up();
  end
  // cut a hang short well past the expected run length
  initial begin
    #(8 * 3000);
    mismatches++;
    wrap_up();
  end
endmodule
